//--- inc/alarm_map.vh
// Purpose: Register offsets, field positions and reset values of the alarm monitor
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes: Definitions only
`ifndef ALARM_MAP_VH
`define ALARM_MAP_VH
`define AM_ADDR_W 6
`define AM_CTRL_OFS 6'h00
`define AM_HIGH_OFS 6'h04
`define AM_LOW_OFS 6'h08
`define AM_HYST_OFS 6'h0C
`define AM_SETP_OFS 6'h10
`define AM_PV_OFS 6'h14
`define AM_STAT_OFS 6'h18
`define AM_IRQ_OFS 6'h1C
`define AM_MASK_OFS 6'h20
`define AM_CMD_OFS 6'h24
`define AM_TICK_OFS 6'h28
// Control fields
`define AM_CTRL_ENABLE 0
`define AM_CTRL_DEV 1
`define AM_CTRL_LATCH 2
`define AM_CTRL_SIL 3
`define AM_CTRL_BLOCK 4
`define AM_CTRL_SRC 5
`define AM_CTRL_RST 32'h0000_0000
// Status fields
`define AM_ST_ACTIVE 0
`define AM_ST_HIGH 1
`define AM_ST_LOW 2
`define AM_ST_SIL 3
`define AM_ST_BLK 4
`define AM_ST_OUT 5
// Command fields
`define AM_CMD_CLEAR 0
`define AM_CMD_SILENCE 1
// Interrupt events
`define AM_EV_W 3
`define AM_EV_RAISE 0
`define AM_EV_CLEAR 1
`define AM_EV_SPCHG 2
// Sample tick default period in aclk cycles
`define AM_TICK_RST 32'h0000_03E8
// Key panel response select codes
`define AM_RESP_CLEAR 1'b0
`define AM_RESP_SILENCE 1'b1
`endif

//--- src/tick_divider.v
// Purpose: Sample tick generator, one-cycle enable pulse every period cycles
// Assumes: Single aclk domain, period of zero or one gives a tick every cycle
// Notes: Period is compared every cycle, count restarts on each tick
`timescale 1ns/1ps
module tick_divider #(
  parameter W = 32
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] period,
  output reg tick
);
  reg [W-1:0] count_reg; // Cycles since last tick

  // Count up and pulse at the end of the period
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= {W{1'b0}};
      tick <= 1'b0;
    end else if (count_reg + {{(W-1){1'b0}}, 1'b1} >= period) begin
      count_reg <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // tick_divider

//--- src/key_panel.v
// Purpose: Front-panel key handling for alarm responses
// Assumes: Keys are level pins from outside the clock domain, active high
// Notes: Up and down toggle the selected response, advance or infinity executes it
`timescale 1ns/1ps
`include "alarm_map.vh"
module key_panel (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] keys_in,
  output reg clear_pulse,
  output reg silence_pulse,
  output reg resp_sel
);
  reg [3:0] sync1_reg; // First synchroniser stage
  reg [3:0] sync2_reg; // Second synchroniser stage
  reg [3:0] prev_reg; // Previous sampled keys
  wire [3:0] press; // Rising edges: 0 up, 1 down, 2 advance, 3 infinity

  // Two-stage synchroniser per key
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      sync1_reg <= keys_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign press = sync2_reg & ~prev_reg;

  // Response selection and execution
  always @(posedge aclk) begin
    if (!aresetn) begin
      resp_sel <= `AM_RESP_CLEAR;
      clear_pulse <= 1'b0;
      silence_pulse <= 1'b0;
    end else begin
      if (press[0] | press[1]) begin
        resp_sel <= ~resp_sel; // RULE_10
      end
      clear_pulse <= (press[2] | press[3]) & (resp_sel == `AM_RESP_CLEAR); // RULE_10
      silence_pulse <= (press[2] | press[3]) & (resp_sel == `AM_RESP_SILENCE); // RULE_10
    end
  end
endmodule // key_panel

//--- src/process_alarm_monitor.v
// Purpose: Alarm supervision with thresholds, hysteresis, latching, silencing, blocking
// Assumes: Signed 16-bit process values, AXI4-Lite register access, one clock
// Notes: Comparisons run once per sample tick from the tick divider
`timescale 1ns/1ps
`include "alarm_map.vh"
// Behaviour
// RULE_01: Alarm when value leaves threshold range
// RULE_02: Active on reaching high or low threshold
// RULE_03: Process mode uses absolute thresholds
// RULE_04: Deviation mode offsets follow set point
// RULE_05: Software keeps high above low, in range
// RULE_06: Clear only past hysteresis zone
// RULE_07: Latched alarm holds until user clear
// RULE_08: Unlatched alarm clears itself after hysteresis
// RULE_09: Active alarm toggles display, shows attention
// RULE_10: Keys select response, advance executes
// RULE_11: Silence forces output off during alarm
// RULE_12: Silence re-arms after normal range return
// RULE_13: Blocking suppresses alarm until normal first
// RULE_14: Deviation set point change re-blocks alarm
// RULE_15: State readable and controllable by software
// RULE_16: Evaluate once per sample tick
module process_alarm_monitor #(
  parameter DW = 16,
  parameter BLINK_TICKS = 8
) (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite register port
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Monitored quantities and panel keys
  input wire [DW-1:0] process_value,
  input wire [DW-1:0] output_level,
  input wire [3:0] keys_in,
  // Alarm drive, display and interrupt
  output reg alarm_out,
  output reg display_show_msg,
  output reg attention_led,
  output reg irq
);
  // Registers
  reg [31:0] ctrl_reg; // Mode bits
  reg [DW-1:0] alarm_high_threshold; // High threshold or offset
  reg [DW-1:0] low_thr_reg; // Low threshold or offset
  reg [DW-1:0] hyst_reg; // Hysteresis
  reg [DW-1:0] setp_reg; // Control set point
  reg [31:0] tick_reg; // Sample period in cycles
  reg [`AM_EV_W-1:0] irq_reg; // Sticky events
  reg [`AM_EV_W-1:0] mask_reg; // Interrupt mask
  reg [DW-1:0] pv_reg; // Sampled monitored quantity
  // Alarm state
  reg high_reg; // High side condition
  reg low_reg; // Low side condition
  reg active_reg; // Reported alarm state
  reg sil_reg; // Silenced
  reg blk_reg; // Blocked
  reg active_prev_reg; // Reported state one cycle ago
  reg spchg_reg; // Set point changed since last tick
  reg [3:0] blink_reg; // Display alternation count
  // Bus
  reg aw_hold_reg; // Write address captured
  reg w_hold_reg; // Write data captured
  reg [`AM_ADDR_W-1:0] awa_reg; // Captured write address
  reg [31:0] wd_reg; // Captured write data
  reg [3:0] ws_reg; // Captured strobes

  // Control fields
  wire alarm_enable = ctrl_reg[`AM_CTRL_ENABLE];
  wire dev_mode = ctrl_reg[`AM_CTRL_DEV];
  wire alarm_latch_enable = ctrl_reg[`AM_CTRL_LATCH];
  wire alarm_silence_enable = ctrl_reg[`AM_CTRL_SIL];
  wire alarm_block_enable = ctrl_reg[`AM_CTRL_BLOCK];
  // Links to the helper modules
  wire tick; // Sample tick
  wire key_clear; // Clear from panel
  wire key_silence; // Silence from panel
  wire resp_sel; // Selected response

  // Sample tick
  tick_divider #(.W(32)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .period(tick_reg),
    .tick(tick)
  );

  // Front-panel keys
  key_panel u_keys (
    .aclk(aclk),
    .aresetn(aresetn),
    .keys_in(keys_in),
    .clear_pulse(key_clear),
    .silence_pulse(key_silence),
    .resp_sel(resp_sel)
  );

  // Effective thresholds, signed arithmetic one bit wider
  wire signed [DW:0] sp_x = {setp_reg[DW-1], setp_reg};
  wire signed [DW:0] hi_x = {alarm_high_threshold[DW-1], alarm_high_threshold};
  wire signed [DW:0] lo_x = {low_thr_reg[DW-1], low_thr_reg};
  wire signed [DW:0] hy_x = {1'b0, hyst_reg};
  wire signed [DW:0] pv_x = {pv_reg[DW-1], pv_reg};
  // Both arms signed, else a negative set point would be zero-extended
  wire signed [DW+1:0] hi_eff = dev_mode ? (sp_x + hi_x) : $signed({hi_x[DW], hi_x}); // RULE_03 RULE_04
  wire signed [DW+1:0] lo_eff = dev_mode ? (sp_x - lo_x) : $signed({lo_x[DW], lo_x}); // RULE_03 RULE_04
  // Value and hysteresis at the same width
  wire signed [DW+1:0] pv_e = {pv_x[DW], pv_x};
  wire signed [DW+1:0] hy_e = {hy_x[DW], hy_x};
  // Trip and release tests against the effective limits
  wire hi_trip = pv_e >= hi_eff; // RULE_02
  wire lo_trip = pv_e <= lo_eff; // RULE_02
  wire hi_rel = pv_e < hi_eff - hy_e; // RULE_06
  wire lo_rel = pv_e > lo_eff + hy_e; // RULE_06
  // Each side holds inside its hysteresis zone
  wire high_next = hi_trip | (high_reg & ~hi_rel); // RULE_06
  wire low_next = lo_trip | (low_reg & ~lo_rel); // RULE_06
  wire normal = ~high_next & ~low_next; // Inside range past hysteresis
  // Clear and silence requests from software or panel
  // Write lands once both halves are held and no response is pending
  wire bus_wr = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire cmd_wr = bus_wr & (awa_reg == `AM_CMD_OFS) & ws_reg[0];
  wire user_clear = key_clear | (cmd_wr & wd_reg[`AM_CMD_CLEAR]); // RULE_15
  wire user_sil = key_silence | (cmd_wr & wd_reg[`AM_CMD_SILENCE]); // RULE_15
  // Set point writes feed the re-block and an event
  wire set_write = bus_wr & (awa_reg == `AM_SETP_OFS);
  // Blocked while not yet armed, or at once after a deviation set point write
  wire blocked = alarm_block_enable & (blk_reg | (dev_mode & spchg_reg)); // RULE_13 RULE_14
  // Events from the edges of the reported state, so each raise and clear counts once
  wire raise_ev = active_reg & ~active_prev_reg;
  wire clear_ev = ~active_reg & active_prev_reg;
  wire [`AM_EV_W-1:0] ev = {set_write, clear_ev, raise_ev};
  // Status word, fields at their mapped positions
  wire [31:0] status_word;
  assign status_word[`AM_ST_ACTIVE] = active_reg;
  assign status_word[`AM_ST_HIGH] = high_reg;
  assign status_word[`AM_ST_LOW] = low_reg;
  assign status_word[`AM_ST_SIL] = sil_reg;
  assign status_word[`AM_ST_BLK] = blk_reg;
  assign status_word[`AM_ST_OUT] = alarm_out;
  assign status_word[`AM_ST_OUT+1] = resp_sel; // Key response select
  assign status_word[31:`AM_ST_OUT+2] = 25'h0000000;

  // Alarm evaluation on each sample tick
  always @(posedge aclk) begin
    if (!aresetn) begin
      pv_reg <= {DW{1'b0}};
      high_reg <= 1'b0;
      low_reg <= 1'b0;
      active_reg <= 1'b0;
      sil_reg <= 1'b0;
      blk_reg <= 1'b1;
      spchg_reg <= 1'b0;
      active_prev_reg <= 1'b0;
    end else begin
      // Sample the chosen quantity
      pv_reg <= ctrl_reg[`AM_CTRL_SRC] ? output_level : process_value; // RULE_01
      active_prev_reg <= active_reg; // Edge source for the alarm events
      if (set_write & dev_mode) begin
        spchg_reg <= 1'b1; // RULE_14
      end
      // Disabled alarm is idle and blocked again
      if (!alarm_enable) begin
        high_reg <= 1'b0;
        low_reg <= 1'b0;
        active_reg <= 1'b0;
        sil_reg <= 1'b0;
        blk_reg <= 1'b1;
      end else if (tick) begin // RULE_16
        // Keep both side conditions
        high_reg <= high_next;
        low_reg <= low_next;
        spchg_reg <= set_write & dev_mode;
        // Blocking: armed after first normal sample, re-blocked on deviation set point change
        if (alarm_block_enable & dev_mode & spchg_reg) begin
          blk_reg <= 1'b1; // RULE_14
        end else if (normal) begin
          blk_reg <= 1'b0; // RULE_13
        end
        // Raise on a live unblocked condition, else drop unless latched
        if ((high_next | low_next) & ~blocked) begin
          active_reg <= 1'b1; // RULE_01
        end else if (~alarm_latch_enable | user_clear) begin
          active_reg <= 1'b0; // RULE_08
        end
        // Silence ends once the value is back in range
        if (normal) begin
          sil_reg <= 1'b0; // RULE_12
        end else if (user_sil & alarm_silence_enable & active_reg) begin
          sil_reg <= 1'b1; // RULE_11
        end
      end else begin
        // Between ticks only user requests act
        if (user_clear & alarm_latch_enable & ~high_reg & ~low_reg) begin
          active_reg <= 1'b0; // RULE_07
        end
        if (user_sil & alarm_silence_enable & active_reg) begin
          sil_reg <= 1'b1; // RULE_11
        end
      end
    end
  end

  // Output drive, display and interrupt
  always @(posedge aclk) begin
    if (!aresetn) begin
      alarm_out <= 1'b0;
      display_show_msg <= 1'b0;
      attention_led <= 1'b0;
      blink_reg <= 4'h0;
      irq <= 1'b0;
    end else begin
      alarm_out <= active_reg & ~sil_reg; // RULE_11
      attention_led <= active_reg; // RULE_09
      // Display alternates only while the alarm stands
      if (!active_reg) begin
        blink_reg <= 4'h0;
        display_show_msg <= 1'b0;
      end else if (tick) begin
        if (blink_reg == BLINK_TICKS[3:0] - 4'h1) begin
          blink_reg <= 4'h0;
          display_show_msg <= ~display_show_msg; // RULE_09
        end else begin
          blink_reg <= blink_reg + 4'h1;
        end
      end
      // Level interrupt from sticky events whose mask bit is set
      irq <= |(irq_reg & mask_reg);
    end
  end

  // AXI4-Lite write channel, address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awa_reg <= {`AM_ADDR_W{1'b0}};
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      ctrl_reg <= `AM_CTRL_RST;
      alarm_high_threshold <= {DW{1'b0}};
      low_thr_reg <= {DW{1'b0}};
      hyst_reg <= {DW{1'b0}};
      setp_reg <= {DW{1'b0}};
      tick_reg <= `AM_TICK_RST;
      mask_reg <= {`AM_EV_W{1'b0}};
      irq_reg <= {`AM_EV_W{1'b0}};
    end else begin
      // Each ready is a one-cycle pulse per accepted beat
      s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awa_reg <= s_axi_awaddr[`AM_ADDR_W-1:0];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      // Sticky events, set wins over write-one-to-clear
      irq_reg <= irq_reg | ev;
      // Register update and response for a held write
      if (bus_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awa_reg)
          `AM_CTRL_OFS: ctrl_reg <= {26'h0, wd_reg[5:0]}; // RULE_15
          `AM_HIGH_OFS: alarm_high_threshold <= wd_reg[DW-1:0];
          `AM_LOW_OFS: low_thr_reg <= wd_reg[DW-1:0];
          `AM_HYST_OFS: hyst_reg <= wd_reg[DW-1:0];
          `AM_SETP_OFS: setp_reg <= wd_reg[DW-1:0];
          `AM_TICK_OFS: tick_reg <= wd_reg;
          `AM_MASK_OFS: mask_reg <= wd_reg[`AM_EV_W-1:0];
          `AM_IRQ_OFS: irq_reg <= (irq_reg & ~wd_reg[`AM_EV_W-1:0]) | ev;
          `AM_CMD_OFS: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2; // Unmapped or read-only
        endcase
      end
      // Response taken, open for the next write
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      // Address ready pulses once, no new read while data waits
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        // Decode while the address is still offered
        case (s_axi_araddr[`AM_ADDR_W-1:0])
          `AM_CTRL_OFS: s_axi_rdata <= ctrl_reg;
          `AM_HIGH_OFS: s_axi_rdata <= {{(32-DW){1'b0}}, alarm_high_threshold};
          `AM_LOW_OFS: s_axi_rdata <= {{(32-DW){1'b0}}, low_thr_reg};
          `AM_HYST_OFS: s_axi_rdata <= {{(32-DW){1'b0}}, hyst_reg};
          `AM_SETP_OFS: s_axi_rdata <= {{(32-DW){1'b0}}, setp_reg};
          `AM_PV_OFS: s_axi_rdata <= {{(32-DW){1'b0}}, pv_reg};
          `AM_STAT_OFS: s_axi_rdata <= status_word; // RULE_15
          `AM_IRQ_OFS: s_axi_rdata <= {29'h0, irq_reg};
          `AM_MASK_OFS: s_axi_rdata <= {29'h0, mask_reg};
          `AM_TICK_OFS: s_axi_rdata <= tick_reg;
          `AM_CMD_OFS: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2; // Unmapped
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // process_alarm_monitor

//--- test/alarm_field_model.sv
// Purpose: Process sensor and front-panel key model
// Assumes: Values change just after a rising edge
// Notes: Released keys read low, as with pull-downs
`timescale 1ns/1ps
module alarm_field_model (
  input wire aclk,
  output reg [15:0] process_value,
  output reg [15:0] output_level,
  output reg [3:0] keys_in
);
  // Idle levels at time zero
  initial begin
    process_value = 16'h0000;
    output_level = 16'h0000;
    keys_in = 4'h0;
  end
  // New output level just after the next edge
  task set_ol(input [15:0] v);
    @(posedge aclk);
    output_level <= v;
  endtask
  // New sensor reading just after the next edge
  task set_pv(input [15:0] v);
    @(posedge aclk);
    process_value <= v;
  endtask
  // One key held past the synchroniser, then released
  task press(input integer k);
    @(posedge aclk);
    keys_in <= 4'h1 << k;
    repeat (6) @(posedge aclk);
    keys_in <= 4'h0;
    repeat (6) @(posedge aclk);
  endtask
endmodule // alarm_field_model

//--- test/process_alarm_monitor_checker.sv
// Purpose: Port-level assertions for the alarm monitor
// Assumes: One aclk domain, tick period of at least 9 cycles
// Notes: Bound to process_alarm_monitor at the foot of this file
`timescale 1ns/1ps
module alarm_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire alarm_out,
  input wire display_show_msg,
  input wire attention_led
);
  // One clock, one reset for every check
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_OUT_NEEDS_STATE: assert property (alarm_out |-> attention_led)
    else $error("alarm drive without alarm state");
  AST_MSG_NEEDS_STATE: assert property (display_show_msg |-> attention_led)
    else $error("message shown without alarm");
  AST_MSG_HOLD: assert property ($rose(display_show_msg) |=> (display_show_msg || !attention_led) [*7])
    else $error("message blink too short");
  AST_STATE_ON_TICK: assert property ($changed(attention_led) |=> $stable(attention_led) [*8])
    else $error("alarm state changed between ticks");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_AR_ANSWER: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than a pulse");
  AST_B_AFTER_TAKE: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
endmodule // alarm_checker
bind process_alarm_monitor alarm_checker alarm_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .alarm_out(alarm_out), .display_show_msg(display_show_msg), .attention_led(attention_led));

//--- test/tb_top.sv
// Purpose: Self-checking bench for the alarm monitor
// Assumes: Tick period set to 10 cycles, so 25 cycles cover two samples
// Notes: Random process values from a fixed seed
`timescale 1ns/1ps
`include "alarm_map.vh"
module tb_top;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] process_value, output_level;
  wire [3:0] keys_in;
  wire alarm_out, display_show_msg, attention_led, irq;
  integer fails = 0, comparisons = 0, i, v;
  integer corner [0:8] = '{100, 95, 89, -100, -95, -89, 99, -99, 0};
  reg [1:0] st = 2'b00;
  reg [31:0] d;
  reg [1:0] r;
  process_alarm_monitor process_alarm_monitor_inst (.*);
  alarm_field_model fld (.aclk(aclk), .process_value(process_value), .output_level(output_level), .keys_in(keys_in));
  // 200 MHz clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task chk(input string n, input [31:0] e, input [31:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write one word, response ready after a random stall
  task wr(input [7:0] a, input [31:0] dv, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // Read one word
  task rd(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // New process value, two samples later compare drive and state
  task step(input integer pv, input [1:0] e);
    fld.set_pv(pv[15:0]);
    repeat (25) @(posedge aclk);
    chk("alarm_state", {30'h0, e}, {30'h0, alarm_out, attention_led});
  endtask
  // Unlatched side conditions {high, low} with +-100 thresholds and 10 hysteresis
  function automatic [1:0] hyst_next(input [1:0] s, input integer pv);
    begin
      hyst_next[1] = (pv >= 100) || (s[1] && pv >= 90);
      hyst_next[0] = (pv <= -100) || (s[0] && pv <= -90);
    end
  endfunction
  task finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (30000) @(posedge aclk);
    fails = fails + 1;
    finish_test;
  end
  // Main sequence
  initial begin
    void'($urandom(32'h1C01));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`AM_CTRL_OFS);
    chk("ctrl", `AM_CTRL_RST, d);
    rd(`AM_TICK_OFS);
    chk("tick", `AM_TICK_RST, d);
    rd(8'h3C);
    chk("unmapped_resp", 32'h2, {30'h0, r});
    chk("unmapped_data", 32'h0, d);
    wr(`AM_PV_OFS, 32'h0, 2'h2);
    $display("test registers done");
    wr(`AM_TICK_OFS, 32'hA, 2'h0);
    wr(`AM_HYST_OFS, 32'hA, 2'h0);
    wr(`AM_HIGH_OFS, 32'h64, 2'h0);
    wr(`AM_LOW_OFS, 32'hFFFF_FF9C, 2'h0);
    wr(`AM_CTRL_OFS, 32'h1, 2'h0);
    for (i = 0; i < 40; i = i + 1) begin
      v = $urandom_range(320);
      v = (i < 9) ? corner[i] : v - 160;
      st = hyst_next(st, v);
      step(v, {|st, |st});
    end
    step(0, 2'b00);
    fld.set_ol(16'h0096);
    wr(`AM_CTRL_OFS, 32'h21, 2'h0);
    step(0, 2'b11);
    wr(`AM_CTRL_OFS, 32'h1, 2'h0);
    step(0, 2'b00);
    wr(`AM_IRQ_OFS, 32'h7, 2'h0);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wr(`AM_MASK_OFS, 32'h1, 2'h0);
    step(120, 2'b11);
    chk("irq_raise", 32'h1, {31'h0, irq});
    rd(`AM_IRQ_OFS);
    chk("irq_bit", 32'h1, {31'h0, d[`AM_EV_RAISE]});
    wr(`AM_MASK_OFS, 32'h0, 2'h0);
    @(posedge aclk);
    chk("irq_mask", 32'h0, {31'h0, irq});
    wr(`AM_IRQ_OFS, 32'h7, 2'h0);
    $display("test process mode done");
    wr(`AM_CTRL_OFS, 32'h5, 2'h0);
    step(0, 2'b11);
    rd(`AM_IRQ_OFS);
    chk("irq_clr_held", 32'h0, {31'h0, d[`AM_EV_CLEAR]});
    fld.press(3);
    step(0, 2'b00);
    rd(`AM_IRQ_OFS);
    chk("irq_clr_done", 32'h1, {31'h0, d[`AM_EV_CLEAR]});
    wr(`AM_CTRL_OFS, 32'h9, 2'h0);
    step(120, 2'b11);
    fld.press(0);
    rd(`AM_STAT_OFS);
    chk("resp_sel", 32'h1, {31'h0, d[6]});
    fld.press(2);
    step(120, 2'b01);
    step(95, 2'b01);
    step(0, 2'b00);
    step(120, 2'b11);
    wr(`AM_CMD_OFS, 32'h2, 2'h0);
    step(120, 2'b01);
    step(0, 2'b00);
    fld.press(1);
    rd(`AM_STAT_OFS);
    chk("resp_sel_back", 32'h0, {31'h0, d[6]});
    $display("test latch and silence done");
    wr(`AM_CTRL_OFS, 32'h0, 2'h0);
    wr(`AM_SETP_OFS, 32'h1F4, 2'h0);
    wr(`AM_HIGH_OFS, 32'h32, 2'h0);
    wr(`AM_LOW_OFS, 32'h32, 2'h0);
    step(600, 2'b00);
    wr(`AM_CTRL_OFS, 32'h13, 2'h0);
    step(600, 2'b00);
    step(500, 2'b00);
    step(550, 2'b11);
    step(500, 2'b00);
    wr(`AM_IRQ_OFS, 32'h7, 2'h0);
    wr(`AM_MASK_OFS, 32'h4, 2'h0);
    wr(`AM_SETP_OFS, 32'h0, 2'h0);
    step(500, 2'b00);
    chk("irq_setp", 32'h1, {31'h0, irq});
    step(0, 2'b00);
    step(60, 2'b11);
    $display("test deviation blocking done");
    finish_test;
  end
endmodule // tb_top
